/* File: sda_defines.vh */
// Register offsets, field positions, reset values and timing counts
`ifndef SDA_DEFINES_VH
`define SDA_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SDA_BANK0_OFF 12'h44c
`define SDA_BANK1_OFF 12'h450
`define SDA_BANK2_OFF 12'h454
`define SDA_BANK3_OFF 12'h458
`define SDA_DEC_OFF 12'h47c
`define SDA_STAT_OFF 12'h480

// ----------------------------------------
// Bank parameter fields
// ----------------------------------------
`define SDA_F_CL 0
`define SDA_F_FT 2
`define SDA_F_RP 3
`define SDA_F_IL4 5
`define SDA_F_W64 6
`define SDA_F_LANE 7
`define SDA_F_ECC 8
`define SDA_F_BYP 9
`define SDA_F_RCD 10
`define SDA_F_BIG 11
`define SDA_F_BL4 13

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SDA_PAR_RST 14'h0000
`define SDA_DEC_RST 3'h0

// ----------------------------------------
// Timing counts in core clocks
// ----------------------------------------
`define SDA_ROW_LEAD 6'h03
`define SDA_ACK_LAG 6'h03
`define SDA_BASE_TWO 6'h02
`define SDA_BEATS4 6'h04
`define SDA_BEATS8 6'h08

`endif

/* File: sda_addr_map.v */
// SDRAM address mapping and per-bank timing sequencer
// Function
// [RULE1] 16 Mbit: row on addr 10..0 plus bank pick 0, column on 9..0
// [RULE2] Address bit 10 is zero in every column strobe cycle
// [RULE3] 16 Mbit banks leave address bit 11 and bank pick 1 unused
// [RULE4] 64/128 Mbit: 12-bit row, both picks; column on bits 11 and 9..0
// [RULE5] Bank pick holds from row strobe through column strobe
// [RULE6] 16 Mbit 64-bit banks map row and column by decode setting
// [RULE7] 64/128 Mbit 64-bit banks map row and column by decode setting
// [RULE8] Row and column widths per density: 12/10, 14/10, 14/11
// [RULE9] Four separate parameter sets, each applied to its own bank
// [RULE10] First read data sampled 2 or 3 clocks after column strobe
// [RULE11] Flow-through sampling bit, forced off when ECC is used
// [RULE12] Precharge to next activation is 2 or 3 clocks
// [RULE13] Interleave two or four banks, only for 64/128 Mbit banks
// [RULE14] Bank data width 32 or 64 bits
// [RULE15] 32-bit bank lane select, ignored for 64-bit banks
// [RULE16] ECC on a 64-bit bank makes it 72 bits wide
// [RULE17] Bypass switch enabled on every CPU read of bypass bank
// [RULE18] No writes through bypass; bypass only on 64-bit banks
// [RULE19] Row to column strobe delay 2 or 3 clocks
// [RULE20] Density bit selects 16 or 64/128 Mbit address mapping
// [RULE21] Burst length 8 or 4 beats
// [RULE22] CPU read first ack 9 clocks with bypass, 10 without; code: 9 to 11 with bypass, 10 to 12 without, by RCD and CAS latency
// [RULE23] Three-bit writable decode setting used for CPU and PCI
// [RULE24] Bypass switch off on writes, other banks and idle
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "sda_defines.vh"

module sda_addr_map (
    input wire clk_i,
    input wire resetn_i,
    input wire ce_i,
    input wire [11:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    input wire acc_req_i,
    input wire [31:0] acc_addr_i,
    input wire [1:0] acc_bank_i,
    input wire acc_wr_i,
    input wire acc_cpu_i,
    output wire acc_ready_o,
    output reg [11:0] mem_addr_out_o,
    output reg [1:0] bank_pick_out_o,
    output reg row_strobe_n_o,
    output reg col_strobe_n_o,
    output reg mem_wr_n_o,
    output reg bypass_switch_oe_n_o,
    output reg cpu_xfer_ack_n_o,
    output reg data_beat_o,
    output reg flow_thru_o,
    output reg lane_hi_o,
    output reg bank_w64_o,
    output reg ecc_on_o,
    output reg interleave_four_o
);

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    reg [13:0] bpar [0:3];
    reg [2:0] dec_sel;
    reg busy;
    reg [5:0] tcnt;
    reg [1:0] a_bank;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_bank
            localparam [31:0] bank_off = `SDA_BANK0_OFF + gi * 4;
            // [RULE9] Own parameter set
            always @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    bpar[gi] <= `SDA_PAR_RST;
                end else if (ce_i && reg_wr_i &&
                        reg_addr_i == bank_off[11:0]) begin
                    bpar[gi] <= reg_wdata_i[13:0];
                end
            end
        end
    endgenerate

    // [RULE23] Decode setting write
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dec_sel <= `SDA_DEC_RST;
        end else if (ce_i && reg_wr_i && reg_addr_i == `SDA_DEC_OFF) begin
            dec_sel <= reg_wdata_i[2:0];
        end
    end

    reg [31:0] next_rdata;
    always @* begin
        next_rdata = 32'h00000000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `SDA_BANK0_OFF: next_rdata = {18'h00000, bpar[0]};
                `SDA_BANK1_OFF: next_rdata = {18'h00000, bpar[1]};
                `SDA_BANK2_OFF: next_rdata = {18'h00000, bpar[2]};
                `SDA_BANK3_OFF: next_rdata = {18'h00000, bpar[3]};
                `SDA_DEC_OFF: next_rdata = {29'h00000000, dec_sel};
                `SDA_STAT_OFF: next_rdata = {23'h000000, busy, a_bank, tcnt};
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (ce_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    // ----------------------------------------
    // Access capture
    // ----------------------------------------
    reg [31:0] a_addr;
    reg a_wr;
    reg a_cpu;
    reg [13:0] a_par;
    reg [2:0] a_dec;
    wire take = acc_req_i && !busy;
    assign acc_ready_o = !busy;

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            a_addr <= 32'h00000000;
            a_bank <= 2'h0;
            a_wr <= 1'b0;
            a_cpu <= 1'b0;
            a_par <= `SDA_PAR_RST;
            a_dec <= `SDA_DEC_RST;
        end else if (ce_i && take) begin
            a_addr <= acc_addr_i;
            a_bank <= acc_bank_i;
            a_wr <= acc_wr_i;
            a_cpu <= acc_cpu_i;
            // [RULE9] Snapshot bank set
            a_par <= bpar[acc_bank_i];
            // [RULE23] Same decode both sources
            a_dec <= dec_sel;
        end
    end

    // ----------------------------------------
    // Per-bank timing figures
    // ----------------------------------------
    wire w64 = a_par[`SDA_F_W64];
    wire big = a_par[`SDA_F_BIG];
    // [RULE19] Row to column delay
    wire [5:0] rcd = `SDA_BASE_TWO + {5'h00, a_par[`SDA_F_RCD]};
    // [RULE10] CAS latency
    wire [5:0] cl = `SDA_BASE_TWO + {5'h00, a_par[`SDA_F_CL]};
    // [RULE12] Precharge recovery
    wire [5:0] rp = `SDA_BASE_TWO + {5'h00, a_par[`SDA_F_RP]};
    // [RULE21] Burst length
    wire [5:0] beats = a_par[`SDA_F_BL4] ? `SDA_BEATS4 : `SDA_BEATS8;
    // [RULE18] Bypass reads on 64-bit only
    wire byp_on = a_par[`SDA_F_BYP] && w64 && a_cpu && !a_wr;
    wire [5:0] t_col = `SDA_ROW_LEAD + rcd;
    wire [5:0] t_dat = t_col + cl;
    // [RULE22] Ack lag 10 to 12 by RCD and CAS latency, one less with bypass
    wire [5:0] t_ack = t_dat + `SDA_ACK_LAG - {5'h00, byp_on};
    wire [5:0] t_end = a_wr ? t_col + beats - 6'h01 : t_ack + beats - 6'h01;
    wire [5:0] t_pre = t_end + 6'h01;
    wire [5:0] t_fin = t_pre + rp - 6'h01;
    wire [5:0] nt = tcnt + 6'h01;
    // ----------------------------------------
    // Address mapping
    // ----------------------------------------
    reg [1:0] bs;
    reg [11:0] ra;
    reg [9:0] c10;
    wire [31:0] a = a_addr;
    always @* begin
        bs = 2'h0;
        ra = 12'h000;
        c10 = 10'h000;
        if (big) begin
            // [RULE7] Dense part decode
            c10 = {a[26:25], a[10:3]};
            case (a_dec)
                3'h0: begin
                    bs = {a[6], a[5]};
                    ra = a[24:13];
                    c10 = {a[26:25], a[12:7], a[4:3]};
                end
                3'h1: begin
                    bs = {a[7], a[6]};
                    ra = a[24:13];
                    c10 = {a[26:25], a[12:8], a[5:3]};
                end
                3'h2: begin
                    bs = {a[12], a[11]};
                    ra = a[24:13];
                end
                3'h3: begin
                    bs = {a[14], a[13]};
                    ra = {a[24:15], a[12:11]};
                end
                3'h4: begin
                    bs = {a[22], a[21]};
                    ra = {a[24:23], a[20:11]};
                end
                3'h5: begin
                    bs = {a[24], a[23]};
                    ra = a[22:11];
                end
                3'h6: begin
                    bs = {a[25], a[24]};
                    ra = a[22:11];
                    c10 = {a[26], a[23], a[10:3]};
                end
                default: begin
                    bs = {a[26], a[25]};
                    ra = a[22:11];
                    c10 = {a[24:23], a[10:3]};
                end
            endcase
        end else begin
            // [RULE6] 16 Mbit decode
            c10 = {a[24:23], a[10:3]};
            case (a_dec)
                3'h0: begin
                    bs = {1'b0, a[5]};
                    ra = {1'b0, a[22:12]};
                    c10 = {a[24:23], a[11:6], a[4:3]};
                end
                3'h1: begin
                    bs = {1'b0, a[6]};
                    ra = {1'b0, a[22:12]};
                    c10 = {a[24:23], a[11:7], a[5:3]};
                end
                3'h2: begin
                    bs = {1'b0, a[11]};
                    ra = {1'b0, a[22:12]};
                end
                3'h3: begin
                    bs = {1'b0, a[13]};
                    ra = {1'b0, a[22:14], a[12:11]};
                end
                3'h4: begin
                    bs = {1'b0, a[21]};
                    ra = {1'b0, a[22], a[20:11]};
                end
                3'h5: begin
                    bs = {1'b0, a[22]};
                    ra = {1'b0, a[21:11]};
                end
                3'h6: begin
                    bs = {1'b0, a[23]};
                    ra = {1'b0, a[22:12]};
                    c10 = {a[24], a[11:3]};
                end
                default: begin
                    bs = {1'b0, a[24]};
                    ra = {1'b0, a[22:12]};
                    c10 = {a[23], a[11:3]};
                end
            endcase
        end
    end

    // [RULE2] Column with bit 10 low
    // [RULE4] Bit 11 carries top column bit
    // [RULE3] Bit 11 zero for 16 Mbit
    // [RULE8] Column width by density
    wire [11:0] ca = {big ? a[27] : 1'b0, 1'b0, c10};

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    reg next_busy;
    reg [5:0] next_tcnt;
    reg [11:0] next_addr;
    reg [1:0] next_bs;
    reg next_ras_n;
    reg next_cas_n;
    reg next_wr_n;
    reg next_byp_n;
    reg next_ack_n;
    reg next_beat;
    always @* begin
        next_busy = busy;
        next_tcnt = tcnt;
        next_addr = mem_addr_out_o;
        next_bs = bank_pick_out_o;
        next_ras_n = 1'b1;
        next_cas_n = 1'b1;
        next_wr_n = 1'b1;
        next_byp_n = 1'b1;
        next_ack_n = 1'b1;
        next_beat = 1'b0;
        if (!busy) begin
            if (take) begin
                next_busy = 1'b1;
                next_tcnt = 6'h01;
            end
        end else if (tcnt == t_fin) begin
            // [RULE12] Recovery done
            next_busy = 1'b0;
            next_tcnt = 6'h00;
        end else begin
            next_tcnt = nt;
            // [RULE1] Row on activation
            if (nt == `SDA_ROW_LEAD) begin
                next_ras_n = 1'b0;
                next_addr = ra;
                // [RULE5] Bank pick set once
                next_bs = bs;
            end
            // [RULE19] Column after delay
            if (nt == t_col) begin
                next_cas_n = 1'b0;
                next_wr_n = !a_wr;
                next_addr = ca;
            end
            if (nt == t_pre) begin
                next_ras_n = 1'b0;
                next_wr_n = 1'b0;
                next_addr = 12'h000;
            end
            // [RULE10] Read sampling window
            if (!a_wr && nt >= t_dat && nt < t_dat + beats) begin
                next_beat = 1'b1;
            end
            if (a_wr && nt >= t_col && nt < t_col + beats) begin
                next_beat = 1'b1;
            end
            // [RULE22] Zero-wait beat acks
            if (a_cpu && (a_wr ? (nt >= t_col && nt < t_col + beats) :
                    (nt >= t_ack && nt < t_ack + beats))) begin
                next_ack_n = 1'b0;
            end
            // [RULE17] Bypass switch on read
            // [RULE24] Off otherwise
            if (byp_on && nt >= t_dat && nt < t_ack + beats) begin
                next_byp_n = 1'b0;
            end
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy <= 1'b0;
            tcnt <= 6'h00;
            mem_addr_out_o <= 12'h000;
            bank_pick_out_o <= 2'h0;
            row_strobe_n_o <= 1'b1;
            col_strobe_n_o <= 1'b1;
            mem_wr_n_o <= 1'b1;
            bypass_switch_oe_n_o <= 1'b1;
            cpu_xfer_ack_n_o <= 1'b1;
            data_beat_o <= 1'b0;
        end else if (ce_i) begin
            busy <= next_busy;
            tcnt <= next_tcnt;
            mem_addr_out_o <= next_addr;
            bank_pick_out_o <= next_bs;
            row_strobe_n_o <= next_ras_n;
            col_strobe_n_o <= next_cas_n;
            mem_wr_n_o <= next_wr_n;
            bypass_switch_oe_n_o <= next_byp_n;
            cpu_xfer_ack_n_o <= next_ack_n;
            data_beat_o <= next_beat;
        end
    end

    // ----------------------------------------
    // Bank data path settings
    // ----------------------------------------
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flow_thru_o <= 1'b0;
            lane_hi_o <= 1'b0;
            bank_w64_o <= 1'b0;
            ecc_on_o <= 1'b0;
            interleave_four_o <= 1'b0;
        end else if (ce_i) begin
            // [RULE11] Flow-through gated
            flow_thru_o <= a_par[`SDA_F_FT] && !byp_on && !(a_par[`SDA_F_ECC] && w64);
            // [RULE15] Lane for 32-bit only
            lane_hi_o <= a_par[`SDA_F_LANE] && !w64;
            // [RULE14] Width select
            bank_w64_o <= w64;
            // [RULE16] ECC on 64-bit bank
            ecc_on_o <= a_par[`SDA_F_ECC] && w64;
            // [RULE13] Four-way for dense
            // [RULE20] Density class
            interleave_four_o <= a_par[`SDA_F_IL4] && big;
        end
    end

endmodule
`default_nettype wire

/* File: sda_addr_map_properties.sv */
// Concurrent checks on the SDRAM address map ports
`timescale 1ns/1ps
`default_nettype none
module sda_addr_map_props (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic acc_ready_o,
    input wire logic [11:0] mem_addr_out_o,
    input wire logic [1:0] bank_pick_out_o,
    input wire logic row_strobe_n_o,
    input wire logic col_strobe_n_o,
    input wire logic mem_wr_n_o,
    input wire logic bypass_switch_oe_n_o,
    input wire logic data_beat_o,
    input wire logic flow_thru_o,
    input wire logic bank_w64_o,
    input wire logic ecc_on_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // --------------------------------
    // Command sequences
    // --------------------------------
    sequence s_act;
        !row_strobe_n_o && mem_wr_n_o;
    endsequence
    sequence s_pre;
        !row_strobe_n_o && !mem_wr_n_o;
    endsequence
    sequence s_rd_col;
        !col_strobe_n_o && mem_wr_n_o;
    endsequence
    // --------------------------------
    // Properties
    // --------------------------------
    a_col_pre_bit: assert property (!col_strobe_n_o |-> mem_addr_out_o[10] == 1'b0)
        else $error("address bit 10 high in column cycle");
    a_bank_moves_row: assert property (!$stable(bank_pick_out_o) |-> s_act)
        else $error("bank pick changed outside activation");
    a_row_col_gap: assert property (s_act |-> ##1 col_strobe_n_o ##[1:2] !col_strobe_n_o)
        else $error("column strobe not 2 or 3 cycles after row");
    a_col_first_beat: assert property (s_rd_col |-> ##[2:3] $rose(data_beat_o))
        else $error("first read beat not 2 or 3 cycles after column");
    a_beats_run: assert property ($rose(data_beat_o) |-> data_beat_o [*4])
        else $error("burst shorter than four beats");
    a_bypass_read_wide: assert property (!bypass_switch_oe_n_o |-> mem_wr_n_o && bank_w64_o)
        else $error("bypass active on write or narrow bank");
    a_idle_bypass_off: assert property (acc_ready_o |-> bypass_switch_oe_n_o)
        else $error("bypass active while idle");
    a_ecc_no_flow: assert property (ecc_on_o |-> !flow_thru_o)
        else $error("flow-through on with ecc");
    a_prech_gap: assert property (s_pre |=> row_strobe_n_o [*2])
        else $error("activation too soon after precharge");
endmodule
bind sda_addr_map sda_addr_map_props u_props (.clk_i(clk_i), .resetn_i(resetn_i),
    .acc_ready_o(acc_ready_o), .mem_addr_out_o(mem_addr_out_o),
    .bank_pick_out_o(bank_pick_out_o), .row_strobe_n_o(row_strobe_n_o),
    .col_strobe_n_o(col_strobe_n_o), .mem_wr_n_o(mem_wr_n_o),
    .bypass_switch_oe_n_o(bypass_switch_oe_n_o), .data_beat_o(data_beat_o),
    .flow_thru_o(flow_thru_o), .bank_w64_o(bank_w64_o), .ecc_on_o(ecc_on_o));
`default_nettype wire

/* File: sda_mem_model.sv */
// SDRAM device model that records each command burst
`timescale 1ns/1ps
`default_nettype none
module sda_mem_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [11:0] mem_addr_i,
    input wire logic [1:0] bank_pick_i,
    input wire logic row_strobe_n_i,
    input wire logic col_strobe_n_i,
    input wire logic mem_wr_n_i,
    input wire logic data_beat_i,
    output logic pre_ev_o,
    output logic [13:0] row_o,
    output logic [13:0] col_o,
    output logic [3:0] rcd_o,
    output logic [3:0] cl_o,
    output logic [3:0] nbeat_o
);
    logic [3:0] t;
    logic [3:0] tcol;
    // Latch row, column, gaps and beat count; flag the closing precharge
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pre_ev_o <= 1'b0;
        end else begin
            t <= t + 4'h1;
            pre_ev_o <= !row_strobe_n_i && !mem_wr_n_i;
            if (!row_strobe_n_i && mem_wr_n_i) begin
                row_o <= {bank_pick_i, mem_addr_i};
                t <= 4'h1;
                nbeat_o <= 4'h0;
            end
            if (!col_strobe_n_i) begin
                col_o <= {bank_pick_i, mem_addr_i};
                rcd_o <= t;
                tcol <= t;
            end
            if (data_beat_i) begin
                nbeat_o <= nbeat_o + 4'h1;
                if (nbeat_o == 4'h0) begin
                    cl_o <= col_strobe_n_i ? t - tcol : 4'h0;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: sda_addr_map_tb_top.sv */
// Self-checking bench for the SDRAM address map
`timescale 1ns/1ps
`default_nettype none
module sda_addr_map_tb_top;
    typedef struct {
        logic [13:0] row;
        logic [13:0] col;
        logic [13:0] m;
        logic [3:0] rcd;
        logic [3:0] cl;
        logic [3:0] nb;
        logic [3:0] lag;
        logic [4:0] fl;
        logic cpu;
        logic byp;
    } sda_exp_t;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce_i = 1'b1;
    logic [11:0] reg_addr_i = 12'h000;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic acc_req_i = 1'b0;
    logic [31:0] acc_addr_i = 32'h0;
    logic [1:0] acc_bank_i = 2'h0;
    logic acc_wr_i = 1'b0;
    logic acc_cpu_i = 1'b0;
    wire [31:0] reg_rdata_o;
    wire [11:0] mem_addr_out_o;
    wire [1:0] bank_pick_out_o;
    wire acc_ready_o, row_strobe_n_o, col_strobe_n_o, mem_wr_n_o, bypass_switch_oe_n_o;
    wire cpu_xfer_ack_n_o, data_beat_o, flow_thru_o, lane_hi_o, bank_w64_o, ecc_on_o;
    wire interleave_four_o, pre_ev;
    wire [13:0] m_row, m_col;
    wire [3:0] m_rcd, m_cl, m_nb;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    int i;
    logic [31:0] a;
    logic [3:0] kk = 4'h0;
    logic [3:0] nack = 4'h0;
    logic [3:0] lag_seen = 4'h0;
    logic byp_seen = 1'b1;
    logic rd_d = 1'b0;
    logic [31:0] rq[$];
    sda_exp_t eq[$];
    sda_exp_t cur;

    always #12.5 clk_i = ~clk_i;

    sda_addr_map u_sda_addr_map (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .acc_req_i(acc_req_i),
        .acc_addr_i(acc_addr_i), .acc_bank_i(acc_bank_i), .acc_wr_i(acc_wr_i),
        .acc_cpu_i(acc_cpu_i), .acc_ready_o(acc_ready_o), .mem_addr_out_o(mem_addr_out_o),
        .bank_pick_out_o(bank_pick_out_o), .row_strobe_n_o(row_strobe_n_o),
        .col_strobe_n_o(col_strobe_n_o), .mem_wr_n_o(mem_wr_n_o),
        .bypass_switch_oe_n_o(bypass_switch_oe_n_o), .cpu_xfer_ack_n_o(cpu_xfer_ack_n_o),
        .data_beat_o(data_beat_o), .flow_thru_o(flow_thru_o), .lane_hi_o(lane_hi_o),
        .bank_w64_o(bank_w64_o), .ecc_on_o(ecc_on_o), .interleave_four_o(interleave_four_o));

    sda_mem_model u_sda_mem_model (.clk_i(clk_i), .resetn_i(resetn_i),
        .mem_addr_i(mem_addr_out_o), .bank_pick_i(bank_pick_out_o),
        .row_strobe_n_i(row_strobe_n_o), .col_strobe_n_i(col_strobe_n_o),
        .mem_wr_n_i(mem_wr_n_o), .data_beat_i(data_beat_o), .pre_ev_o(pre_ev),
        .row_o(m_row), .col_o(m_col), .rcd_o(m_rcd), .cl_o(m_cl), .nbeat_o(m_nb));

    // --------------------------------
    // Tasks
    // --------------------------------
    task automatic end_sim;
        if (n_mismatch == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_rd_i <= 1'b0;
        reg_addr_i <= ad;
        reg_wdata_i <= d;
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_wr_i <= 1'b0;
        reg_addr_i <= ad;
        rq.push_back(d);
    endtask
    task automatic idle;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        reg_wr_i <= 1'b0;
    endtask
    task automatic acc(input logic [1:0] b, input logic w, input sda_exp_t e);
        while (acc_ready_o !== 1'b1) @(negedge clk_i);
        eq.push_back(e);
        @(posedge clk_i);
        acc_req_i <= 1'b1;
        acc_addr_i <= a;
        acc_bank_i <= b;
        acc_wr_i <= w;
        acc_cpu_i <= e.cpu;
        @(posedge clk_i);
        acc_req_i <= 1'b0;
        @(negedge clk_i);
    endtask

    // --------------------------------
    // Output watcher
    // --------------------------------
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            end_sim();
        end
        rd_d <= reg_rd_i;
        if (rd_d) chk(reg_rdata_o, rq.pop_front(), "rdata"); // Register data
        kk <= kk + 4'h1;
        if (row_strobe_n_o === 1'b0 && mem_wr_n_o === 1'b1) begin
            kk <= 4'h1;
            nack <= 4'h0;
        end
        if (cpu_xfer_ack_n_o === 1'b0) begin
            nack <= nack + 4'h1;
            if (nack == 4'h0) begin
                lag_seen <= kk;
                byp_seen <= bypass_switch_oe_n_o;
            end
        end
        if (pre_ev === 1'b1) begin
            cur = eq.pop_front();
            chk(32'(m_row & cur.m), 32'(cur.row & cur.m), "row"); // Row
            chk(32'(m_col & cur.m), 32'(cur.col & cur.m), "col"); // Column
            chk(32'(m_rcd), 32'(cur.rcd), "rcd"); // Gap
            chk(32'(m_cl), 32'(cur.cl), "cl"); // Latency
            chk(32'(m_nb), 32'(cur.nb), "beats"); // Burst
            chk(32'(nack), cur.cpu ? 32'(cur.nb) : 32'h0, "acks"); // Acks
            chk({27'h0, flow_thru_o, lane_hi_o, bank_w64_o, ecc_on_o, interleave_four_o},
                32'(cur.fl), "flags"); // Flags
            if (cur.cpu) begin
                chk(32'(lag_seen), 32'(cur.lag), "lag"); // Ack lag
                chk(32'(byp_seen), 32'(cur.byp), "bypass"); // Bypass
            end
        end
    end

    // --------------------------------
    // Main sequence
    // --------------------------------
    initial begin
        void'($urandom(32'hba544856));
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        for (i = 0; i < 4; i++) rd(12'h44c + 12'(4 * i), 32'h0);
        rd(12'h47c, 32'h0);
        rd(12'h7fc, 32'h0);
        wr(12'h44c, 32'hffffffff);
        wr(12'h47c, 32'hffffffff);
        wr(12'h7fc, 32'hffffffff);
        rd(12'h44c, 32'h00003fff);
        rd(12'h47c, 32'h00000007);
        rd(12'h7fc, 32'h0);
        wr(12'h44c, 32'h0);
        wr(12'h450, 32'h2e41);
        wr(12'h454, 32'h034c);
        wr(12'h458, 32'h08a4);
        wr(12'h47c, 32'h0);
        rd(12'h44c, 32'h0);
        rd(12'h450, 32'h2e41);
        idle();
        ce_i <= 1'b0;
        wr(12'h44c, 32'h1);
        idle();
        ce_i <= 1'b1;
        rd(12'h44c, 32'h0);
        idle();
        a = $urandom();
        acc(2'd0, 1'b0, '{{1'b0, a[5], 1'b0, a[22:12]},
            {1'b0, a[5], 2'b0, a[24:23], a[11:6], a[4:3]}, 14'h3fff,
            4'd2, 4'd2, 4'd8, 4'd7, 5'b00000, 1'b1, 1'b1});
        a = $urandom();
        acc(2'd1, 1'b0, '{{a[6], a[5], a[24:13]},
            {a[6], a[5], a[27], 1'b0, a[26:25], a[12:7], a[4:3]}, 14'h3fff,
            4'd3, 4'd3, 4'd4, 4'd8, 5'b00100, 1'b1, 1'b0});
        wr(12'h47c, 32'h7);
        idle();
        a = $urandom();
        acc(2'd2, 1'b1, '{{1'b0, a[24], 1'b0, a[22:12]},
            {1'b0, a[24], 2'b0, a[23], a[11:3]}, 14'h3fff,
            4'd2, 4'd0, 4'd8, 4'd2, 5'b00110, 1'b1, 1'b1});
        wr(12'h47c, 32'h0);
        idle();
        a = $urandom();
        acc(2'd3, 1'b0, '{{a[6], a[5], a[24:13]},
            {a[6], a[5], a[27], 1'b0, a[26:25], a[12:7], a[4:3]}, 14'h3fff,
            4'd2, 4'd2, 4'd8, 4'd0, 5'b11001, 1'b0, 1'b1});
        while (eq.size() != 0) @(posedge clk_i);
        end_sim();
    end
endmodule
`default_nettype wire
